/* File: design/hpm_defs.svh */
// Register indexes, field positions, reset values and writable masks for haptic mode control
`ifndef HPM_DEFS_SVH
`define HPM_DEFS_SVH

// Register indexes; byte address is four times the index
`define HPM_IDX_MODE    6'h01
`define HPM_IDX_RTV     6'h02
`define HPM_IDX_LIB     6'h03
`define HPM_IDX_FIRE    6'h0c
`define HPM_IDX_RATED   6'h16
`define HPM_IDX_CTRL    6'h1d
`define HPM_IDX_STAT    6'h1e

// Reset values
`define HPM_MODE_RST    8'h40
`define HPM_RTV_RST     8'h00
`define HPM_LIB_RST     8'h00
`define HPM_RATED_RST   8'h3f
`define HPM_CTRL_RST    8'h00

// Writable bits per register
`define HPM_MODE_MASK   8'h47
`define HPM_RTV_MASK    8'hff
`define HPM_LIB_MASK    8'h17
`define HPM_RATED_MASK  8'hff
`define HPM_CTRL_MASK   8'h0a

// Field positions
`define HPM_B_DEVRST    7
`define HPM_B_STBY      6
`define HPM_B_HIZ       4
`define HPM_B_FMT       3
`define HPM_B_ANALOG    1
`define HPM_B_FIRE      0

// Mode field values
`define HPM_M_INT       3'h0
`define HPM_M_EDGE      3'h1
`define HPM_M_LEVEL     3'h2
`define HPM_M_PWM       3'h3
`define HPM_M_AUDIO     3'h4
`define HPM_M_RTP       3'h5
`define HPM_M_DIAG      3'h6
`define HPM_M_CAL       3'h7

// Bus responses
`define HPM_RESP_OKAY   2'h0
`define HPM_RESP_SLVERR 2'h2

// Duty measurement frame: last position of a 255-sample frame
`define HPM_PWM_LAST    8'hfe

`endif

/* File: design/hpm_pkg.sv */
// Shared types for haptic playback mode control
package hpm_pkg;

  typedef enum logic [1:0] {
    HPM_ACT_NONE,
    HPM_ACT_SEQ,
    HPM_ACT_DIAG,
    HPM_ACT_CAL
  } hpm_action_e;

  typedef logic [5:0] hpm_idx_t;
  typedef logic [7:0] hpm_byte_t;

endpackage : hpm_pkg

/* File: design/hpm_pwm_duty.sv */
// Duty-cycle meter for the PWM drive reference on the trigger pin
`timescale 1ns/100ps
`include "hpm_defs.svh"

module hpm_pwm_duty (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  // Pin and result
  input  wire logic             i_pin,
  output hpm_pkg::hpm_byte_t    o_duty
);
  import hpm_pkg::*;

  hpm_byte_t pos_q;
  hpm_byte_t acc_q;
  hpm_byte_t duty_q;

  // 255 samples per frame so that 100 % lands exactly on 8'hff
  wire       last   = (pos_q == `HPM_PWM_LAST);
  hpm_byte_t acc_nx;
  assign acc_nx = acc_q + {7'h00, i_pin};
  assign o_duty = duty_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos_q  <= 8'h00;
      acc_q  <= 8'h00;
      duty_q <= 8'h00;
    end else begin
      pos_q <= last ? 8'h00 : pos_q + 8'h01;
      acc_q <= last ? 8'h00 : acc_nx;
      if (last) begin
        duty_q <= acc_nx;
      end
    end
  end

endmodule : hpm_pwm_duty

/* File: design/hpm_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
`include "hpm_defs.svh"

module hpm_axil_slave (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  // Write address and data
  input  wire logic [7:0]       i_axi_awaddr,
  input  wire logic             i_axi_awvalid,
  output logic                  o_axi_awready,
  input  wire logic [31:0]      i_axi_wdata,
  input  wire logic [3:0]       i_axi_wstrb,
  input  wire logic             i_axi_wvalid,
  output logic                  o_axi_wready,
  output logic [1:0]            o_axi_bresp,
  output logic                  o_axi_bvalid,
  input  wire logic             i_axi_bready,
  // Read address and data
  input  wire logic [7:0]       i_axi_araddr,
  input  wire logic             i_axi_arvalid,
  output logic                  o_axi_arready,
  output logic [31:0]           o_axi_rdata,
  output logic [1:0]            o_axi_rresp,
  output logic                  o_axi_rvalid,
  input  wire logic             i_axi_rready,
  // Register side
  output logic                  o_wr_en,
  output hpm_pkg::hpm_idx_t     o_wr_idx,
  output hpm_pkg::hpm_byte_t    o_wr_data,
  input  wire logic             i_wr_hit,
  output hpm_pkg::hpm_idx_t     o_rd_idx,
  input  wire hpm_pkg::hpm_byte_t i_rd_data,
  input  wire logic             i_rd_hit
);
  import hpm_pkg::*;

  logic        aw_full_q;
  logic        w_full_q;
  logic        w_lane_q;
  hpm_idx_t    aw_idx_q;
  hpm_byte_t   w_data_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  wire wr_go   = aw_full_q && w_full_q && !bvalid_q;
  wire aw_take = i_axi_awvalid && o_axi_awready;
  wire w_take  = i_axi_wvalid && o_axi_wready;
  wire ar_take = i_axi_arvalid && o_axi_arready;

  assign o_axi_awready = !aw_full_q && !bvalid_q;
  assign o_axi_wready  = !w_full_q && !bvalid_q;
  assign o_axi_arready = !rvalid_q;
  assign o_axi_bvalid  = bvalid_q;
  assign o_axi_bresp   = bresp_q;
  assign o_axi_rvalid  = rvalid_q;
  assign o_axi_rresp   = rresp_q;
  assign o_axi_rdata   = rdata_q;
  // Only byte lane 0 carries register data
  assign o_wr_en       = wr_go && w_lane_q;
  assign o_wr_idx      = aw_idx_q;
  assign o_wr_data     = w_data_q;
  assign o_rd_idx      = i_axi_araddr[7:2];

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_full_q <= 1'b0;
      aw_idx_q  <= 6'h00;
    end else if (aw_take) begin
      aw_full_q <= 1'b1;
      aw_idx_q  <= i_axi_awaddr[7:2];
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_full_q <= 1'b0;
      w_lane_q <= 1'b0;
      w_data_q <= 8'h00;
    end else if (w_take) begin
      w_full_q <= 1'b1;
      w_lane_q <= i_axi_wstrb[0];
      w_data_q <= i_axi_wdata[7:0];
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `HPM_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= i_wr_hit ? `HPM_RESP_OKAY : `HPM_RESP_SLVERR;
    end else if (i_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `HPM_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= i_rd_hit ? `HPM_RESP_OKAY : `HPM_RESP_SLVERR;
      rdata_q  <= i_rd_hit ? {24'h00_0000, i_rd_data} : 32'h0000_0000;
    end else if (i_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : hpm_axil_slave

/* File: design/hpm_mode_ctrl.sv */
// Haptic playback mode and trigger control with its register file
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "hpm_defs.svh"

// Behaviour
// R1: Level-trigger mode: playback-fire bit follows the trigger pin.
// R2: Level-trigger mode: pin rising edge sets playback-fire and starts playback.
// R3: Level-trigger mode: pin falling edge cancels ongoing playback.
// R4: Level-trigger mode: an edge matching the current fire state changes nothing.
// R5: Mode 3: PWM on the trigger pin becomes the drive reference.
// R6: PWM/analog mode drives the actuator continuously without any trigger.
// R7: Pulse-or-analog select switches the pin from PWM decode to analog input.
// R8: Mode 5: the 8-bit real-time drive value is applied to the load.
// R9: Host may rewrite the real-time value anytime; each new value is applied.
// R10: Real-time value is two's-complement signed after reset.
// R11: Format select set makes the real-time value unsigned.
// R12: Host parks after real-time playback via mode 0 or standby.
// R13: Playback-fire uses the library chosen by the 3-bit library select.
// R14: Mode field selects the fired action; mode 0 fires sequence playback.
// R15: Fire bit holds until sequence ends then clears; host clear cancels.
// R16: Host writes rated drive level before starting auto calibration.
// R17: Edge mode: rising edge sets fire; second rising edge before clear cancels.
// R18: Diagnostic and calibration start on fire and self-clear when finished.
module hpm_mode_ctrl (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  // AXI4-Lite write channels
  input  wire logic [7:0]       i_axi_awaddr,
  input  wire logic             i_axi_awvalid,
  output logic                  o_axi_awready,
  input  wire logic [31:0]      i_axi_wdata,
  input  wire logic [3:0]       i_axi_wstrb,
  input  wire logic             i_axi_wvalid,
  output logic                  o_axi_wready,
  output logic [1:0]            o_axi_bresp,
  output logic                  o_axi_bvalid,
  input  wire logic             i_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]       i_axi_araddr,
  input  wire logic             i_axi_arvalid,
  output logic                  o_axi_arready,
  output logic [31:0]           o_axi_rdata,
  output logic [1:0]            o_axi_rresp,
  output logic                  o_axi_rvalid,
  input  wire logic             i_axi_rready,
  // Trigger pin and its analog sample
  input  wire logic             i_input_trigger_pin,
  input  wire hpm_pkg::hpm_byte_t i_analog_level,
  // Playback engine
  input  wire logic             i_engine_done,
  output logic                  o_fire,
  output logic                  o_start,
  output logic                  o_cancel,
  output hpm_pkg::hpm_action_e  o_action,
  output logic [2:0]            o_effect_library_select,
  output hpm_pkg::hpm_byte_t    o_rated_level,
  // Output stage
  output logic                  o_drive_en,
  output logic [8:0]            o_drive_level,
  output logic                  o_analog_src,
  output logic                  o_output_high_impedance_select,
  output logic                  o_standby
);
  import hpm_pkg::*;

  localparam int NREG = 5;

  // Storage table: index, reset value and writable bits per entry
  localparam hpm_idx_t REG_IDX [NREG] = '{
    `HPM_IDX_MODE, `HPM_IDX_RTV, `HPM_IDX_LIB, `HPM_IDX_RATED, `HPM_IDX_CTRL
  };
  localparam hpm_byte_t REG_RST [NREG] = '{
    `HPM_MODE_RST, `HPM_RTV_RST, `HPM_LIB_RST, `HPM_RATED_RST, `HPM_CTRL_RST
  };
  localparam hpm_byte_t REG_MASK [NREG] = '{
    `HPM_MODE_MASK, `HPM_RTV_MASK, `HPM_LIB_MASK, `HPM_RATED_MASK, `HPM_CTRL_MASK
  };

  // Bus side
  logic        wr_en;
  hpm_idx_t    wr_idx;
  hpm_byte_t   wr_data;
  logic        wr_hit;
  hpm_idx_t    rd_idx;
  hpm_byte_t   rd_data;
  logic        rd_hit;

  // Storage and control state
  hpm_byte_t   reg_q [NREG];
  logic        fire_q;
  logic        start_q;
  logic        cancel_q;
  logic        trig_q;
  hpm_action_e action_q;
  logic        drive_en_q;
  logic [8:0]  drive_level_q;
  hpm_byte_t   duty;

  hpm_axil_slave u_bus (
    .i_mclk        (i_mclk),
    .i_nrst        (i_nrst),
    .i_axi_awaddr  (i_axi_awaddr),
    .i_axi_awvalid (i_axi_awvalid),
    .o_axi_awready (o_axi_awready),
    .i_axi_wdata   (i_axi_wdata),
    .i_axi_wstrb   (i_axi_wstrb),
    .i_axi_wvalid  (i_axi_wvalid),
    .o_axi_wready  (o_axi_wready),
    .o_axi_bresp   (o_axi_bresp),
    .o_axi_bvalid  (o_axi_bvalid),
    .i_axi_bready  (i_axi_bready),
    .i_axi_araddr  (i_axi_araddr),
    .i_axi_arvalid (i_axi_arvalid),
    .o_axi_arready (o_axi_arready),
    .o_axi_rdata   (o_axi_rdata),
    .o_axi_rresp   (o_axi_rresp),
    .o_axi_rvalid  (o_axi_rvalid),
    .i_axi_rready  (i_axi_rready),
    .o_wr_en       (wr_en),
    .o_wr_idx      (wr_idx),
    .o_wr_data     (wr_data),
    .i_wr_hit      (wr_hit),
    .o_rd_idx      (rd_idx),
    .i_rd_data     (rd_data),
    .i_rd_hit      (rd_hit)
  );

  // Pin is sampled every cycle, so the meter runs in every mode
  hpm_pwm_duty u_duty (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_pin  (i_input_trigger_pin),
    .o_duty (duty)
  );

  // Field views
  wire [2:0] mode    = reg_q[0][2:0];
  wire       standby = reg_q[0][`HPM_B_STBY];
  wire [7:0] rtv     = reg_q[1];
  wire       fmt_uns = reg_q[4][`HPM_B_FMT];
  wire       analog  = reg_q[4][`HPM_B_ANALOG];

  // Write decode
  wire wr_mode  = wr_en && (wr_idx == `HPM_IDX_MODE);
  wire wr_fire  = wr_en && (wr_idx == `HPM_IDX_FIRE);
  // Device reset bit is never stored; it restores every default
  wire soft_rst = wr_mode && wr_data[`HPM_B_DEVRST];

  // Register file, one entry per generate pass
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    wire hit = wr_en && (wr_idx == REG_IDX[g]);
    always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
        reg_q[g] <= REG_RST[g]; // R10
      end else if (soft_rst) begin
        reg_q[g] <= REG_RST[g];
      end else if (hit) begin
        reg_q[g] <= wr_data & REG_MASK[g]; // R9
      end
    end
  end

  // Read decode and write acceptance
  always_comb begin
    rd_data = 8'h00;
    rd_hit  = 1'b0;
    wr_hit  = (wr_idx == `HPM_IDX_FIRE);
    for (int i = 0; i < NREG; i++) begin
      if (rd_idx == REG_IDX[i]) begin
        rd_data = reg_q[i];
        rd_hit  = 1'b1;
      end
      if (wr_idx == REG_IDX[i]) begin
        wr_hit = 1'b1;
      end
    end
    if (rd_idx == `HPM_IDX_FIRE) begin
      rd_data = {7'h00, fire_q};
      rd_hit  = 1'b1;
    end
    if (rd_idx == `HPM_IDX_STAT) begin
      rd_data = {4'h0, analog, i_input_trigger_pin, drive_en_q, fire_q};
      rd_hit  = 1'b1;
    end
  end

  // Trigger pin edges
  wire trig_rise = i_input_trigger_pin && !trig_q;
  wire trig_fall = !i_input_trigger_pin && trig_q;
  wire m_edge    = (mode == `HPM_M_EDGE);
  wire m_level   = (mode == `HPM_M_LEVEL);

  // Software fire writes; writing the held value does nothing
  wire sw_set  = wr_fire && wr_data[`HPM_B_FIRE] && !fire_q;
  wire sw_clr  = wr_fire && !wr_data[`HPM_B_FIRE] && fire_q; // R15

  // Edge mode: a second rise while firing is a cancel
  wire edg_set = m_edge && trig_rise && !fire_q; // R17
  wire edg_clr = m_edge && trig_rise && fire_q; // R17

  // Level mode: only edges that change the bit take effect
  wire lvl_set = m_level && trig_rise && !fire_q; // R1 R2 R4
  wire lvl_clr = m_level && trig_fall && fire_q; // R1 R3 R4

  // Engine reports sequence or procedure completion
  wire done_clr = i_engine_done && fire_q; // R15 R18

  wire fire_set = (sw_set || edg_set || lvl_set) && !standby && !soft_rst;
  wire fire_clr = sw_clr || edg_clr || lvl_clr || done_clr || standby || soft_rst;

  // A fire write in the cycle of a completion is dropped, as the bit is still set
  wire fire_d = fire_set ? 1'b1 : (fire_clr ? 1'b0 : fire_q);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      trig_q   <= 1'b0;
      fire_q   <= 1'b0;
      start_q  <= 1'b0;
      cancel_q <= 1'b0;
    end else begin
      trig_q   <= i_input_trigger_pin;
      fire_q   <= fire_d; // R15
      start_q  <= fire_d && !fire_q;
      // Self-clear on completion is not a cancel
      cancel_q <= !fire_d && fire_q && !i_engine_done;
    end
  end

  // Action that the fire bit launches
  hpm_action_e action_d;
  always_comb begin
    case (mode)
      `HPM_M_INT:   action_d = HPM_ACT_SEQ; // R14
      `HPM_M_EDGE:  action_d = HPM_ACT_SEQ; // R14
      `HPM_M_LEVEL: action_d = HPM_ACT_SEQ; // R14
      `HPM_M_DIAG:  action_d = HPM_ACT_DIAG; // R18
      `HPM_M_CAL:   action_d = HPM_ACT_CAL; // R18
      default:      action_d = HPM_ACT_NONE;
    endcase
  end

  // Continuous drive modes need no trigger
  wire m_pwm      = (mode == `HPM_M_PWM);
  wire m_rtp      = (mode == `HPM_M_RTP);
  wire drive_en_d = !standby && (m_pwm || m_rtp); // R6 R8 R12

  // Drive reference as 9-bit two's complement
  wire [8:0] rtp_level = fmt_uns ? {1'b0, rtv} : {rtv[7], rtv}; // R10 R11
  wire [7:0] pin_ref   = analog ? i_analog_level : duty; // R5 R7
  wire [8:0] level_d   = !drive_en_d ? 9'h000 :
                         (m_rtp ? rtp_level : {1'b0, pin_ref}); // R8 R9

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      action_q      <= HPM_ACT_NONE;
      drive_en_q    <= 1'b0;
      drive_level_q <= 9'h000;
    end else begin
      action_q      <= action_d;
      drive_en_q    <= drive_en_d; // R6
      drive_level_q <= level_d; // R9
    end
  end

  // Outputs
  assign o_fire                         = fire_q;
  assign o_start                        = start_q;
  assign o_cancel                       = cancel_q;
  assign o_action                       = action_q;
  assign o_effect_library_select        = reg_q[2][2:0]; // R13
  assign o_output_high_impedance_select = reg_q[2][`HPM_B_HIZ];
  // Calibration reads this as its full-scale reference
  assign o_rated_level                  = reg_q[3]; // R16
  assign o_drive_en                     = drive_en_q;
  assign o_drive_level                  = drive_level_q;
  assign o_analog_src                   = analog; // R7
  assign o_standby                      = standby; // R12

endmodule : hpm_mode_ctrl

/* File: verif/hpm_engine_model.sv */
// Playback engine stand-in that reports completion after a set delay
`timescale 1ns/100ps
module hpm_engine_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // Control from the block and delay from the bench
  input  wire logic       i_start,
  input  wire logic       i_cancel,
  input  wire logic [9:0] i_dly,
  // Completion pulse
  output logic            o_done
);
  logic [9:0] cnt_q;
  // Zero delay never finishes, standing in for endless playback
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= 10'h000;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt_q == 10'h001);
      if (i_start) begin
        cnt_q <= i_dly;
      end else if (i_cancel || cnt_q == 10'h001) begin
        cnt_q <= 10'h000;
      end else if (cnt_q != 10'h000) begin
        cnt_q <= cnt_q - 10'h001;
      end
    end
  end
endmodule : hpm_engine_model

/* File: verif/hpm_mode_ctrl_assertions.sv */
// Concurrent checks on the mode control ports
`timescale 1ns/100ps
module hpm_mode_ctrl_assertions (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  // Observed ports
  input wire logic        o_fire,
  input wire logic        o_start,
  input wire logic        o_cancel,
  input wire logic        i_engine_done,
  input wire logic        o_drive_en,
  input wire logic [8:0]  o_drive_level,
  input wire logic        o_standby,
  input wire logic        o_axi_bvalid,
  input wire logic [1:0]  o_axi_bresp,
  input wire logic        i_axi_bready,
  input wire logic        o_axi_awready,
  input wire logic        o_axi_wready,
  input wire logic        o_axi_rvalid,
  input wire logic [31:0] o_axi_rdata,
  input wire logic        i_axi_rready
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  property p_start;
    o_start |-> o_fire && !$past(o_fire);
  endproperty
  property p_cancel;
    o_cancel |-> !o_fire && $past(o_fire);
  endproperty
  // Self-clear must not look like a cancel to the engine
  property p_done;
    o_fire && i_engine_done |=> !o_fire && !o_cancel;
  endproperty
  property p_stby;
    o_standby && $past(o_standby) |-> !o_fire && !o_drive_en;
  endproperty
  property p_idle;
    !o_drive_en |-> o_drive_level == 9'h000;
  endproperty
  property p_bhold;
    o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp);
  endproperty
  property p_rhold;
    o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata);
  endproperty
  property p_wblk;
    o_axi_bvalid |-> !o_axi_awready && !o_axi_wready;
  endproperty
  a_start: assert property (p_start) else $error("start without fire rise");
  a_cancel: assert property (p_cancel) else $error("cancel without fire fall");
  a_done: assert property (p_done) else $error("done did not self-clear");
  a_stby: assert property (p_stby) else $error("active in standby");
  a_idle: assert property (p_idle) else $error("drive level while idle");
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_wblk: assert property (p_wblk) else $error("write taken while busy");
  c_start: cover property (o_start);
  c_cancel: cover property (o_cancel);
  c_drive: cover property (o_drive_en && o_drive_level != 9'h000);
endmodule : hpm_mode_ctrl_assertions

bind hpm_mode_ctrl hpm_mode_ctrl_assertions u_chk (.i_mclk, .i_nrst, .o_fire, .o_start,
  .o_cancel, .i_engine_done, .o_drive_en, .o_drive_level, .o_standby, .o_axi_bvalid,
  .o_axi_bresp, .i_axi_bready, .o_axi_awready, .o_axi_wready, .o_axi_rvalid,
  .o_axi_rdata, .i_axi_rready);

/* File: verif/hpm_mode_ctrl_test.sv */
// Self-checking bench for haptic playback mode control
`timescale 1ns/100ps
`include "hpm_defs.svh"
module hpm_mode_ctrl_test;
  import hpm_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic [7:0]  i_axi_awaddr = 8'h00;
  logic [7:0]  i_axi_araddr = 8'h00;
  logic [31:0] i_axi_wdata = 32'h0;
  logic [3:0]  i_axi_wstrb = 4'hf;
  logic        i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
  logic        i_axi_arvalid = 1'b0, i_axi_rready = 1'b0, i_input_trigger_pin = 1'b0;
  hpm_byte_t   i_analog_level = 8'h00;
  logic [9:0]  eng_dly = 10'h000;
  logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0]  o_axi_bresp, o_axi_rresp;
  logic [31:0] o_axi_rdata;
  logic        i_engine_done, o_fire, o_start, o_cancel, o_drive_en, o_analog_src;
  logic        o_output_high_impedance_select, o_standby;
  hpm_action_e o_action;
  logic [2:0]  o_effect_library_select;
  hpm_byte_t   o_rated_level;
  logic [8:0]  o_drive_level;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;

  initial forever #12.5 i_mclk = ~i_mclk;

  hpm_mode_ctrl dut (.i_mclk, .i_nrst, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready,
    .i_axi_wdata, .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid,
    .i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata,
    .o_axi_rresp, .o_axi_rvalid, .i_axi_rready, .i_input_trigger_pin, .i_analog_level,
    .i_engine_done, .o_fire, .o_start, .o_cancel, .o_action, .o_effect_library_select,
    .o_rated_level, .o_drive_en, .o_drive_level, .o_analog_src,
    .o_output_high_impedance_select, .o_standby);
  hpm_engine_model u_eng (.i_mclk, .i_nrst, .i_start(o_start), .i_cancel(o_cancel),
    .i_dly(eng_dly), .o_done(i_engine_done));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick
  task automatic axw(input hpm_idx_t idx, input hpm_byte_t d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    i_axi_awaddr  <= {idx, 2'b00};
    i_axi_wdata   <= {24'h0, d};
    i_axi_awvalid <= 1'b1;
    i_axi_wvalid  <= 1'b1;
    i_axi_bready  <= 1'b1;
    // Each channel is released only at the edge that took it
    while (aw || w) begin
      @(posedge i_mclk);
      if (o_axi_awready === 1'b1) aw = 1'b0;
      if (o_axi_wready === 1'b1) w = 1'b0;
      i_axi_awvalid <= aw;
      i_axi_wvalid  <= w;
    end
    do @(posedge i_mclk); while (o_axi_bvalid !== 1'b1);
    i_axi_bready <= 1'b0;
    chk(o_axi_bresp, er);
    // Edge between transfers so the next call never re-drives bready in this step
    @(posedge i_mclk);
  endtask : axw
  task automatic axr(input hpm_idx_t idx, input hpm_byte_t ed, input logic [1:0] er);
    i_axi_araddr  <= {idx, 2'b00};
    i_axi_arvalid <= 1'b1;
    i_axi_rready  <= 1'b1;
    do @(posedge i_mclk); while (o_axi_arready !== 1'b1);
    i_axi_arvalid <= 1'b0;
    do @(posedge i_mclk); while (o_axi_rvalid !== 1'b1);
    i_axi_rready <= 1'b0;
    chk(o_axi_rdata, {24'h0, ed});
    chk(o_axi_rresp, er);
    // Edge between transfers so the next call never re-drives rready in this step
    @(posedge i_mclk);
  endtask : axr
  task automatic t_regs;
    axr(`HPM_IDX_MODE, 8'h40, 2'h0);
    axr(`HPM_IDX_RTV, 8'h00, 2'h0);
    axr(`HPM_IDX_LIB, 8'h00, 2'h0);
    axr(`HPM_IDX_RATED, 8'h3f, 2'h0);
    axr(`HPM_IDX_CTRL, 8'h00, 2'h0);
    axr(6'h3f, 8'h00, 2'h2);
    axw(`HPM_IDX_STAT, 8'hff, 2'h2);
    chk(o_standby, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_seq;
    axw(`HPM_IDX_MODE, 8'h00, 2'h0);
    axw(`HPM_IDX_LIB, 8'h15, 2'h0);
    axr(`HPM_IDX_LIB, 8'h15, 2'h0);
    chk(o_effect_library_select, 3'h5);
    chk(o_output_high_impedance_select, 1'b1);
    eng_dly <= 10'd20;
    axw(`HPM_IDX_FIRE, 8'h01, 2'h0);
    tick(2);
    chk(o_fire, 1'b1);
    chk(o_action, HPM_ACT_SEQ);
    tick(30);
    chk(o_fire, 1'b0);
    eng_dly <= 10'd200;
    axw(`HPM_IDX_FIRE, 8'h01, 2'h0);
    tick(2);
    axw(`HPM_IDX_FIRE, 8'h00, 2'h0);
    tick(2);
    chk(o_fire, 1'b0);
    $display("test seq done");
  endtask : t_seq
  task automatic t_edge;
    eng_dly <= 10'd0;
    axw(`HPM_IDX_MODE, 8'h01, 2'h0);
    for (int k = 0; k < 2; k++) begin
      i_input_trigger_pin <= 1'b1;
      tick(2);
      i_input_trigger_pin <= 1'b0;
      tick(3);
      chk(o_fire, k == 0);
    end
    $display("test edge done");
  endtask : t_edge
  task automatic t_level;
    axw(`HPM_IDX_MODE, 8'h02, 2'h0);
    i_input_trigger_pin <= 1'b1;
    tick(3);
    chk(o_fire, 1'b1);
    tick(8);
    chk(o_fire, 1'b1);
    i_input_trigger_pin <= 1'b0;
    tick(3);
    chk(o_fire, 1'b0);
    axw(`HPM_IDX_FIRE, 8'h01, 2'h0);
    i_input_trigger_pin <= 1'b1;
    tick(3);
    chk(o_fire, 1'b1);
    i_input_trigger_pin <= 1'b0;
    tick(3);
    chk(o_fire, 1'b0);
    $display("test level done");
  endtask : t_level
  task automatic t_realtime;
    axw(`HPM_IDX_MODE, 8'h05, 2'h0);
    axw(`HPM_IDX_RTV, 8'h80, 2'h0);
    tick(2);
    chk(o_drive_en, 1'b1);
    chk(o_drive_level, 9'h180);
    axw(`HPM_IDX_RTV, 8'h7f, 2'h0);
    tick(2);
    chk(o_drive_level, 9'h07f);
    axw(`HPM_IDX_CTRL, 8'h08, 2'h0);
    axw(`HPM_IDX_RTV, 8'h80, 2'h0);
    tick(2);
    chk(o_drive_level, 9'h080);
    axw(`HPM_IDX_MODE, 8'h45, 2'h0);
    tick(2);
    chk(o_drive_en, 1'b0);
    $display("test realtime done");
  endtask : t_realtime
  task automatic t_pwm;
    i_input_trigger_pin <= 1'b1;
    axw(`HPM_IDX_MODE, 8'h03, 2'h0);
    // Two frames so one full all-high frame is latched
    tick(520);
    chk(o_drive_en, 1'b1);
    chk(o_drive_level, 9'h0ff);
    i_analog_level <= 8'h5a;
    axw(`HPM_IDX_CTRL, 8'h02, 2'h0);
    tick(2);
    chk(o_analog_src, 1'b1);
    chk(o_drive_level, 9'h05a);
    i_input_trigger_pin <= 1'b0;
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_proc;
    eng_dly <= 10'd6;
    axw(`HPM_IDX_RATED, 8'h50, 2'h0);
    tick(2);
    chk(o_rated_level, 8'h50);
    for (int k = 6; k < 8; k++) begin
      axw(`HPM_IDX_MODE, k[7:0], 2'h0);
      axw(`HPM_IDX_FIRE, 8'h01, 2'h0);
      tick(2);
      chk(o_fire, 1'b1);
      chk(o_action, (k == 6) ? HPM_ACT_DIAG : HPM_ACT_CAL);
      tick(12);
      chk(o_fire, 1'b0);
    end
    axw(`HPM_IDX_MODE, 8'h80, 2'h0);
    tick(2);
    chk(o_rated_level, 8'h3f);
    axr(`HPM_IDX_MODE, 8'h40, 2'h0);
    $display("test proc done");
  endtask : t_proc
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    tick(8);
    i_nrst <= 1'b1;
    tick(2);
    t_regs;
    t_seq;
    t_edge;
    t_level;
    t_realtime;
    t_pwm;
    t_proc;
    test_done;
  end
endmodule : hpm_mode_ctrl_test
